// ===== tcsr_consts.svh
// register offsets, field positions and reset values for the touch status bank
`ifndef TCSR_CONSTS_SVH
`define TCSR_CONSTS_SVH

`define TCSR_NUM_CH 3
`define TCSR_ADDR_MAIN_CONTROL 8'h00
`define TCSR_ADDR_GENERAL_STATUS 8'h02
`define TCSR_ADDR_CH_TOUCH_STATUS 8'h03
`define TCSR_MAIN_CONTROL_RST 8'h00

// main control fields
`define TCSR_MC_INT 0
`define TCSR_MC_COMBO 1
`define TCSR_MC_CGAIN_LO 2
`define TCSR_MC_CGAIN_HI 3
`define TCSR_MC_DEEPEST_LOW_POWER_REQ 4
`define TCSR_MC_STANDBY_REQ 5
`define TCSR_MC_GAIN_LO 6
`define TCSR_MC_GAIN_HI 7

// general status fields
`define TCSR_GS_TOUCH 0
`define TCSR_GS_PATTERN 1
`define TCSR_GS_MULTI 2
`define TCSR_GS_HOLD 4
`define TCSR_GS_CAL_ERR 5
`define TCSR_GS_BASE_LIMIT 6

`endif

// ===== tcsr_pkg.sv
// types shared by the touch control and status register bank
package tcsr_pkg;
   typedef enum logic [1:0] {
      TCSR_PS_ACTIVE,
      TCSR_PS_STANDBY,
      TCSR_PS_COMBINED,
      TCSR_PS_DEEP_SLEEP
   } tcsr_power_state_t;
endpackage

// ===== tcsr_top.sv
// main control and status registers of a three-channel touch sensor
//
// Operation
// [R01] power state priority: deep sleep, then combined, then standby, else active
// [R02] gain code 00,01,10,11 decodes to analog gain 1,2,4,8
// [R03] combined off: main gain everywhere; on: secondary gain for standby inputs; code keeps main gain on inputs also active-enabled
// [R04] any gain field change triggers recalibration of every input from scratch
// [R05] standby scans standby inputs only; dropped inputs release and stay idle
// [R06] combined scans active and standby inputs; dropped inputs release
// [R07] deep sleep stops scanning, clears all status and the pending bit
// [R08] alert output is low whenever the pending bit is set
// [R09] touch on channel without interrupt enable never sets pending bit
// [R10] host writes zero to clear pending; alert releases, stale status clears
// [R11] base-limit flag bit 6 while any enabled input has base out of limit; code checks active-enabled inputs only
// [R12] calibration-failure flag bit 5 until every enabled input calibrates; code checks active-enabled inputs only
// [R13] hold flag bit 4 sets pending; clears with pending if touch ended
// [R14] multi-touch blocking flag bit 2 never sets the pending bit
// [R15] pattern flag bit 1 sets pending only if pattern alerts enabled
// [R16] summary touch bit 0 is OR of per-channel touch bits
// [R17] main control resets to 00h: active, unity gain, nothing pending
// [R18] channel touch status holds channels one to three in bits 0 to 2
// [R19] channel bit clears only after pending cleared and touch gone
// [R20] new touch on interrupt-enabled channel sets the pending bit
`timescale 1ns/1ps
`include "tcsr_consts.svh"

module tcsr_top
   import tcsr_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // register access from the serial bus front end
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // per-channel configuration from other register banks
   input wire logic [2:0] active_en_in,
   input wire logic [2:0] standby_en_in,
   input wire logic [2:0] irq_en_in,
   input wire logic pattern_irq_en_in,
   // sensing results
   input wire logic [2:0] touch_in,
   input wire logic [2:0] base_out_in,
   input wire logic [2:0] cal_fail_in,
   input wire logic hold_button_held_in,
   input wire logic hold_button_touch_in,
   input wire logic multi_block_in,
   input wire logic pattern_hit_in,
   // controls toward the sensing core
   output tcsr_power_state_t power_state_out,
   output logic [2:0] scan_en_out,
   output logic [11:0] ch_gain_out,
   output logic recal_all_out,
   // alert pin
   output logic alert_n_out
);

   ////////////////////////////////////////////////////////////////////////
   // main control register

   logic [7:0] main_control_q;
   logic wr_main;
   logic int_clear;
   logic int_set;
   logic deepest_low_power_req;
   logic combo;
   logic standby_req;
   logic [1:0] gain_code;
   logic [1:0] cgain_code;

   assign wr_main = reg_wr_in && (reg_addr_in == `TCSR_ADDR_MAIN_CONTROL);
   assign int_clear = wr_main && !reg_wdata_in[`TCSR_MC_INT]; // see [R10]
   assign deepest_low_power_req = main_control_q[`TCSR_MC_DEEPEST_LOW_POWER_REQ];
   assign combo = main_control_q[`TCSR_MC_COMBO];
   assign standby_req = main_control_q[`TCSR_MC_STANDBY_REQ];
   assign gain_code = main_control_q[`TCSR_MC_GAIN_HI:`TCSR_MC_GAIN_LO];
   assign cgain_code = main_control_q[`TCSR_MC_CGAIN_HI:`TCSR_MC_CGAIN_LO];

   // writing a one to the pending bit does nothing; only hardware sets it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         main_control_q <= `TCSR_MAIN_CONTROL_RST; // see [R17]
      end else begin
         if (wr_main) begin
            main_control_q[7:1] <= reg_wdata_in[7:1];
         end
         if (wr_main && reg_wdata_in[`TCSR_MC_DEEPEST_LOW_POWER_REQ]) begin
            main_control_q[`TCSR_MC_INT] <= 1'b0; // see [R07]
         end else if (int_set) begin
            // a new event wins over a clear in the same cycle, unless that write also sets the deep sleep request bit
            main_control_q[`TCSR_MC_INT] <= 1'b1; // see [R20]
         end else if (int_clear) begin
            main_control_q[`TCSR_MC_INT] <= 1'b0; // see [R10]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power state and scanning

   tcsr_power_state_t ps_d;
   logic [2:0] scan_d;

   always_comb begin
      if (deepest_low_power_req) begin
         ps_d = TCSR_PS_DEEP_SLEEP; // see [R01]
         scan_d = 3'h0; // see [R07]
      end else if (combo) begin
         ps_d = TCSR_PS_COMBINED;
         scan_d = active_en_in | standby_en_in; // see [R06]
      end else if (standby_req) begin
         ps_d = TCSR_PS_STANDBY;
         scan_d = standby_en_in; // see [R05]
      end else begin
         ps_d = TCSR_PS_ACTIVE;
         scan_d = active_en_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         power_state_out <= TCSR_PS_ACTIVE;
      end else begin
         power_state_out <= ps_d; // see [R01]
      end
   end

   // the sensing core sees the scan set in the same cycle as the new power state output
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scan_en_out <= 3'h0;
      end else begin
         scan_en_out <= scan_d; // see [R05] [R06]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // gain selection and recalibration

   logic main_gain_chg;
   logic combo_gain_chg;
   logic gain_chg;

   // a write that only touches power bits leaves calibration alone;
   // only a real change of either gain field restarts it
   assign main_gain_chg =
      reg_wdata_in[`TCSR_MC_GAIN_HI:`TCSR_MC_GAIN_LO] != gain_code;
   assign combo_gain_chg =
      reg_wdata_in[`TCSR_MC_CGAIN_HI:`TCSR_MC_CGAIN_LO] != cgain_code;
   assign gain_chg = main_gain_chg || combo_gain_chg;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         recal_all_out <= 1'b0;
      end else begin
         recal_all_out <= wr_main && gain_chg; // see [R04]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel touch status

   logic [2:0] ch_touch_q;
   logic [2:0] eff_touch_q;
   logic [2:0] eff_touch;
   logic [2:0] new_touch;

   // an input that drops out of scanning looks released from then on
   assign eff_touch = touch_in & scan_d; // see [R05]
   assign new_touch = eff_touch & ~eff_touch_q;

   genvar gi;
   generate
      for (gi = 0; gi < `TCSR_NUM_CH; gi++) begin : g_ch
         logic [1:0] code;
         // active-enabled inputs keep the main gain in combined state
         assign code = (combo && standby_en_in[gi] && !active_en_in[gi]) ?
                       cgain_code : gain_code; // see [R03]

         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               ch_gain_out[gi*4 +: 4] <= 4'h1;
            end else begin
               ch_gain_out[gi*4 +: 4] <= 4'h1 << code; // see [R02]
            end
         end

         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               ch_touch_q[gi] <= 1'b0;
               eff_touch_q[gi] <= 1'b0;
            end else begin
               eff_touch_q[gi] <= eff_touch[gi];
               if (deepest_low_power_req) begin
                  ch_touch_q[gi] <= 1'b0; // see [R07]
               end else if (eff_touch[gi]) begin
                  ch_touch_q[gi] <= 1'b1; // see [R18]
               end else if (int_clear) begin
                  ch_touch_q[gi] <= 1'b0; // see [R19]
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // general status

   logic hold_q;
   logic hold_seen_q;
   logic pattern_q;
   logic pattern_seen_q;
   logic base_limit_q;
   logic cal_err_q;
   logic multi_q;
   logic hold_rise;
   logic pattern_rise;

   assign hold_rise = hold_button_held_in && !hold_seen_q && !deepest_low_power_req;
   assign pattern_rise = pattern_hit_in && !pattern_seen_q && !deepest_low_power_req;
   logic touch_irq;
   logic pattern_irq;

   // only enabled touches, hold and enabled pattern raise the pending bit
   assign touch_irq = |(new_touch & irq_en_in); // see [R09]
   assign pattern_irq = pattern_rise && pattern_irq_en_in; // see [R15]
   // the multi-touch block is deliberately left out of this sum
   assign int_set = touch_irq || hold_rise || pattern_irq; // see [R14] [R13]

   // edge memories keep a lasting condition from raising a second event
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hold_seen_q <= 1'b0;
      end else begin
         hold_seen_q <= hold_button_held_in && !deepest_low_power_req;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pattern_seen_q <= 1'b0;
      end else begin
         pattern_seen_q <= pattern_hit_in && !deepest_low_power_req;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hold_q <= 1'b0;
      end else if (deepest_low_power_req) begin
         hold_q <= 1'b0; // see [R07]
      end else if (hold_button_held_in) begin
         hold_q <= 1'b1; // see [R13]
      end else if (int_clear && !hold_button_touch_in) begin
         hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pattern_q <= 1'b0;
      end else if (deepest_low_power_req) begin
         pattern_q <= 1'b0; // see [R07]
      end else if (pattern_hit_in) begin
         pattern_q <= 1'b1; // see [R15]
      end else if (int_clear) begin
         pattern_q <= 1'b0;
      end
   end

   // level flags follow their causes; base-limit and calibration flags look at active-enabled inputs only
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         base_limit_q <= 1'b0;
      end else begin
         base_limit_q <= !deepest_low_power_req && |(base_out_in & active_en_in); // see [R11]
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cal_err_q <= 1'b0;
      end else begin
         cal_err_q <= !deepest_low_power_req && |(cal_fail_in & active_en_in); // see [R12]
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         multi_q <= 1'b0;
      end else begin
         multi_q <= !deepest_low_power_req && multi_block_in; // see [R14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data and alert

   logic [7:0] gen_status;

   always_comb begin
      gen_status = 8'h00;
      gen_status[`TCSR_GS_TOUCH] = |ch_touch_q; // see [R16]
      gen_status[`TCSR_GS_PATTERN] = pattern_q;
      gen_status[`TCSR_GS_MULTI] = multi_q;
      gen_status[`TCSR_GS_HOLD] = hold_q;
      gen_status[`TCSR_GS_CAL_ERR] = cal_err_q;
      gen_status[`TCSR_GS_BASE_LIMIT] = base_limit_q;
   end

   logic [7:0] rd_d;

   // unmapped addresses read as zero
   always_comb begin
      unique case (reg_addr_in)
         `TCSR_ADDR_MAIN_CONTROL: rd_d = main_control_q;
         `TCSR_ADDR_GENERAL_STATUS: rd_d = gen_status;
         `TCSR_ADDR_CH_TOUCH_STATUS: rd_d = {5'h00, ch_touch_q}; // see [R18]
         default: rd_d = 8'h00;
      endcase
   end

   // read data holds until the next read so a slow front end can take it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_d;
      end
   end

   // the alert follows the pending bit one cycle later
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         alert_n_out <= 1'b1;
      end else begin
         alert_n_out <= !main_control_q[`TCSR_MC_INT]; // see [R08]
      end
   end

endmodule

// ===== tcsr_top_assertions.sv
// concurrent checks on the touch control and status register bank
`timescale 1ns/1ps
module tcsr_checker
   import tcsr_pkg::*;
(
   // clock, reset and register strobes
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   // events
   input wire logic [2:0] irq_en_in,
   input wire logic [2:0] touch_in,
   input wire logic hold_button_held_in,
   input wire logic pattern_hit_in,
   // outputs
   input tcsr_power_state_t power_state_out,
   input wire logic [2:0] scan_en_out,
   input wire logic [11:0] ch_gain_out,
   input wire logic recal_all_out,
   input wire logic alert_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   logic [3:0] gains_q;
   logic [1:0] gn_q;
   logic [2:0] eff_q;
   tcsr_power_state_t ps_q;
   wire mc_wr = reg_wr_in && reg_addr_in == 8'h00;
   wire [2:0] new_w = touch_in & scan_en_out & ~eff_q & irq_en_in;
   wire quiet = touch_in == 3'h0 && !hold_button_held_in && !pattern_hit_in;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gains_q <= 4'h0;
         gn_q <= 2'h0;
         eff_q <= 3'h0;
         ps_q <= TCSR_PS_ACTIVE;
      end else begin
         eff_q <= touch_in & scan_en_out;
         if (mc_wr) begin
            gains_q <= {reg_wdata_in[7:6], reg_wdata_in[3:2]};
            gn_q <= reg_wdata_in[7:6];
            ps_q <= reg_wdata_in[4] ? TCSR_PS_DEEP_SLEEP :
               reg_wdata_in[1] ? TCSR_PS_COMBINED :
               reg_wdata_in[5] ? TCSR_PS_STANDBY : TCSR_PS_ACTIVE;
         end
      end
   end
   power_prio_a: assert property (
      mc_wr ##1 !reg_wr_in |-> ##1 power_state_out == ps_q)
      else $error("power state does not follow written priority");
   gain_decode_a: assert property (
      (mc_wr && !reg_wdata_in[1]) ##1 !reg_wr_in [*2]
      |-> ch_gain_out == {3{4'h1 << gn_q}})
      else $error("channel gain does not match main gain code");
   sleep_quiet_a: assert property (
      power_state_out == TCSR_PS_DEEP_SLEEP |-> scan_en_out == 3'h0
      && alert_n_out) else $error("deep sleep still scans or alerts");
   recal_on_a: assert property (
      mc_wr && {reg_wdata_in[7:6], reg_wdata_in[3:2]} != gains_q
      |=> recal_all_out) else $error("gain change without recalibration");
   recal_off_a: assert property (
      mc_wr && {reg_wdata_in[7:6], reg_wdata_in[3:2]} == gains_q
      |=> !recal_all_out) else $error("recalibration without gain change");
   recal_cause_a: assert property (
      $rose(recal_all_out) |-> $past(mc_wr))
      else $error("recalibration pulse without a control write");
   alert_set_a: assert property (
      (|new_w && !reg_wr_in) ##1 !reg_wr_in |-> ##1 !alert_n_out)
      else $error("enabled touch did not assert alert");
   alert_clr_a: assert property (
      (mc_wr && !reg_wdata_in[0] && quiet) ##1 (quiet && !reg_wr_in)
      |-> ##1 alert_n_out) else $error("alert not released on clear");
endmodule
bind tcsr_top tcsr_checker tcsr_checker_i (.*);

// ===== tcsr_host_model.sv
// host model issuing single-byte register transfers
`timescale 1ns/1ps
module tcsr_host_model (
   // register strobes toward the device
   input wire logic clk_in,
   output logic reg_wr_in,
   output logic reg_rd_in,
   output logic [7:0] reg_addr_in,
   output logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out
);
   initial begin
      reg_wr_in = 1'h0;
      reg_rd_in = 1'h0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
   end
   // idle address and data are inverted so stale values never look valid
   task automatic xfer(input logic w, input logic [7:0] a, d);
      @(posedge clk_in);
      #1;
      reg_wr_in = w;
      reg_rd_in = !w;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(posedge clk_in);
      #1;
      reg_wr_in = 1'h0;
      reg_rd_in = 1'h0;
      reg_addr_in = ~a;
      reg_wdata_in = ~d;
   endtask
   task automatic wr(input logic [7:0] a, d);
      xfer(1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      xfer(1'h0, a, 8'h00);
      d = reg_rdata_out;
   endtask
endmodule

// ===== tcsr_top_tb.sv
// self-checking bench for the touch control and status register bank
`timescale 1ns/1ps
module tcsr_top_tb
   import tcsr_pkg::*;
;
   logic clk_in = 1'h0, resetn_in = 1'h0, reg_wr_in, reg_rd_in, recal_all_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [2:0] active_en_in = 3'h3, standby_en_in = 3'h4, irq_en_in = 3'h0;
   logic [2:0] touch_in = 3'h0, base_out_in = 3'h0, cal_fail_in = 3'h0;
   logic hold_button_held_in = 1'h0, hold_button_touch_in = 1'h0;
   logic multi_block_in = 1'h0, pattern_hit_in = 1'h0;
   logic pattern_irq_en_in = 1'h0, alert_n_out;
   logic [2:0] scan_en_out;
   logic [11:0] ch_gain_out;
   tcsr_power_state_t power_state_out;
   int mismatches = 0, num_checks = 0, cyc = 0;
   tcsr_top tcsr_top_i (.*);
   tcsr_host_model tcsr_host_model_i (.*);
   initial forever #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         results();
      end
   end
   task automatic chk(input logic [11:0] s, e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, e);
      logic [7:0] d;
      tcsr_host_model_i.rd(a, d);
      chk(d, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic clr();
      tcsr_host_model_i.wr(8'h00, 8'h00);
      tick(2);
   endtask
   task automatic t_power();
      logic [7:0] mc [4] = '{8'h00, 8'h20, 8'h22, 8'h32};
      logic [2:0] sc [4] = '{3'h3, 3'h4, 3'h7, 3'h0};
      tcsr_power_state_t ps [4] = '{TCSR_PS_ACTIVE, TCSR_PS_STANDBY,
         TCSR_PS_COMBINED, TCSR_PS_DEEP_SLEEP};
      rdchk(8'h00, 8'h00);
      rdchk(8'h05, 8'h00);
      chk(ch_gain_out, 12'h111);
      tcsr_host_model_i.wr(8'h00, 8'h01);
      tick(2);
      rdchk(8'h00, 8'h00);
      for (int i = 0; i < 4; i++) begin
         tcsr_host_model_i.wr(8'h00, mc[i]);
         tick(2);
         chk(power_state_out, ps[i]);
         chk(scan_en_out, sc[i]);
         rdchk(8'h00, mc[i]);
      end
      clr();
      $display("power test done");
   endtask
   task automatic t_gain();
      for (int g = 0; g < 4; g++) begin
         tcsr_host_model_i.wr(8'h00, {g[1:0], 6'h00});
         chk(recal_all_out, g != 0);
         tick(2);
         chk(ch_gain_out, {3{4'h1 << g}});
      end
      tcsr_host_model_i.wr(8'h00, 8'h4A);
      chk(recal_all_out, 1'h1);
      tick(2);
      chk(ch_gain_out, 12'h422);
      clr();
      $display("gain test done");
   endtask
   task automatic t_reset();
      tcsr_host_model_i.wr(8'h00, 8'hC6);
      tick(2);
      chk(ch_gain_out, 12'h288);
      resetn_in = 1'h0;
      tick(2);
      chk(ch_gain_out, 12'h111);
      chk(power_state_out, TCSR_PS_ACTIVE);
      chk(alert_n_out, 1'h1);
      resetn_in = 1'h1;
      rdchk(8'h00, 8'h00);
      chk(scan_en_out, 3'h3);
      $display("reset test done");
   endtask
   task automatic t_touch();
      touch_in = 3'h1;
      tick(3);
      chk(alert_n_out, 1'h1);
      rdchk(8'h03, 8'h01);
      rdchk(8'h02, 8'h01);
      touch_in = 3'h0;
      clr();
      rdchk(8'h03, 8'h00);
      irq_en_in = 3'h2;
      touch_in = 3'h2;
      tick(3);
      chk(alert_n_out, 1'h0);
      rdchk(8'h00, 8'h01);
      rdchk(8'h03, 8'h02);
      clr();
      chk(alert_n_out, 1'h1);
      rdchk(8'h03, 8'h02);
      touch_in = 3'h0;
      clr();
      rdchk(8'h03, 8'h00);
      rdchk(8'h02, 8'h00);
      $display("touch test done");
   endtask
   task automatic t_standby();
      irq_en_in = 3'h0;
      touch_in = 3'h1;
      tick(3);
      rdchk(8'h03, 8'h01);
      tcsr_host_model_i.wr(8'h00, 8'h20);
      tick(2);
      rdchk(8'h03, 8'h01);
      tcsr_host_model_i.wr(8'h00, 8'h20);
      tick(2);
      rdchk(8'h03, 8'h00);
      touch_in = 3'h5;
      tick(3);
      rdchk(8'h03, 8'h04);
      touch_in = 3'h0;
      clr();
      rdchk(8'h03, 8'h00);
      $display("standby test done");
   endtask
   task automatic t_flags();
      base_out_in = 3'h1;
      cal_fail_in = 3'h2;
      multi_block_in = 1'h1;
      tick(2);
      rdchk(8'h02, 8'h64);
      chk(alert_n_out, 1'h1);
      base_out_in = 3'h4;
      cal_fail_in = 3'h0;
      multi_block_in = 1'h0;
      tick(2);
      rdchk(8'h02, 8'h00);
      base_out_in = 3'h0;
      pattern_hit_in = 1'h1;
      tick(3);
      rdchk(8'h02, 8'h02);
      chk(alert_n_out, 1'h1);
      pattern_hit_in = 1'h0;
      clr();
      rdchk(8'h02, 8'h00);
      pattern_irq_en_in = 1'h1;
      pattern_hit_in = 1'h1;
      tick(3);
      chk(alert_n_out, 1'h0);
      pattern_hit_in = 1'h0;
      clr();
      hold_button_held_in = 1'h1;
      hold_button_touch_in = 1'h1;
      touch_in = 3'h1;
      tick(3);
      chk(alert_n_out, 1'h0);
      rdchk(8'h02, 8'h11);
      hold_button_held_in = 1'h0;
      clr();
      rdchk(8'h02, 8'h11);
      hold_button_touch_in = 1'h0;
      clr();
      rdchk(8'h02, 8'h01);
      pattern_hit_in = 1'h1;
      tick(3);
      chk(alert_n_out, 1'h0);
      tcsr_host_model_i.wr(8'h00, 8'h10);
      tick(2);
      rdchk(8'h02, 8'h00);
      rdchk(8'h03, 8'h00);
      rdchk(8'h00, 8'h10);
      chk(alert_n_out, 1'h1);
      pattern_hit_in = 1'h0;
      $display("flag test done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      tick(20);
      resetn_in = 1'h1;
      t_power();
      t_gain();
      t_reset();
      t_touch();
      t_standby();
      t_flags();
      results();
   end
endmodule
